// ===== bench/ospt_top_tb.sv
// self-checking bench for the one-shot pulse timer over axi4-lite
`timescale 1ns/1ns
`default_nettype none
`include "ospt_params.svh"
module ospt_top_tb;
   logic aclk, aresetn, awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv, p0, pmi;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, rdv, cyc, fail_count, checks_done;
   logic [1:0] br, rr, rs;
   logic [3:1] pulse_pin, chirq;
   logic [3:0] pv;
   logic [2:0] prot;
   logic [3:0] ws, wsel;
   logic [31:0] rise [4], fall [4], irqt [4], nrise [4], nirq [4];
   wire logic trg, evt;
   wire logic [3:0] pins = {pulse_pin, p0};
   wire logic [3:0] irqs = {chirq, pmi};
   ospt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(prot),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arprot(prot), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rre), .ext_trigger_pin(trg), .ext_event_pin(evt),
      .output_zero_pin(p0), .pulse_output_pin(pulse_pin), .period_match_irq(pmi),
      .channel_match_irq(chirq));
   ospt_trig_src src (.aclk(aclk), .ext_trigger_pin(trg), .ext_event_pin(evt));
   // clock at 250 MHz
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // pin edges and irq pulses, sampled mid-cycle where all are settled
   always @(negedge aclk) begin
      cyc++;
      for (int k = 0; k < 4; k++) begin
         if (pins[k] === 1'b1 && pv[k] !== 1'b1) begin
            rise[k] = cyc;
            nrise[k]++;
         end
         if (pins[k] !== 1'b1 && pv[k] === 1'b1)
            fall[k] = cyc;
         if (irqs[k] === 1'b1) begin
            irqt[k] = cyc;
            nirq[k]++;
         end
      end
      pv = pins;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // write: address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      @(posedge aclk);
      awa <= a;
      wd <= v;
      ws <= wsel;
      // protection bits vary with the strobe pattern; the slave ignores them
      prot <= wsel[2:0];
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = awv && awr;
         tw = wv && wrdy;
         tb = bv;
         rs = br;
         @(posedge aclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) bre <= 1'b0;
      end
   endtask
   task automatic axr(input logic [7:0] a);
      logic ta, tr;
      @(posedge aclk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge aclk);
         ta = arv && arr;
         tr = rv;
         rdv = rdat;
         rs = rr;
         @(posedge aclk);
         if (ta) arv <= 1'b0;
         if (tr) rre <= 1'b0;
      end
   endtask
   // one triggered shot; the hardware case also retriggers and reads mid-run
   task automatic shot(input logic [15:0] c0, c1, c2, c3, input bit hw);
      logic [15:0] c [4];
      c = '{c0, c1, c2, c3};
      for (int k = 0; k < 4; k++)
         axw(`OSPT_OFS_CCR0 + 8'(4 * k), {16'h0000, c[k]});
      axw(`OSPT_OFS_IOC0, 32'h00000055);
      axw(`OSPT_OFS_CTL1, 32'h00000003);
      axw(`OSPT_OFS_CTL0, 32'h00000080);
      axr(`OSPT_OFS_STAT);
      chk(rdv, 32'h00000002);
      for (int k = 0; k < 4; k++) begin
         nrise[k] = 0;
         nirq[k] = 0;
      end
      if (hw) begin
         src.fire(1'b0);
         axw(`OSPT_OFS_CTL1, 32'h00000043);
         axr(`OSPT_OFS_CNT);
         chk(32'(rdv <= {16'h0000, c0}), 32'h00000001);
      end else
         axw(`OSPT_OFS_CTL1, 32'h00000043);
      repeat (c0 + 40) @(posedge aclk);
      chk(nrise[0], 32'h00000001);
      chk(fall[0] - rise[0], c0 + 32'h1);
      chk(nirq[0], 32'h00000001);
      chk(irqt[0], fall[0] - 32'h1);
      for (int k = 1; k < 4; k++) begin
         if (c[k] <= c0) begin
            chk(rise[k] - rise[0], c[k]);
            chk(fall[k] - rise[k], c0 - c[k] + 32'h1);
            chk(fall[k], fall[0]);
            chk(irqt[k], rise[k] - 32'h1);
         end
         chk(nrise[k], 32'(c[k] <= c0));
         chk(nirq[k], 32'(c[k] <= c0));
      end
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h0000ffff);
      axr(`OSPT_OFS_STAT);
      chk(rdv, 32'h00000002);
   endtask
   // cut a hang short well past the expected run length
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      finish_test();
   end
   // main sequence
   initial begin
      {aresetn, awv, wv, bre, arv, rre, awa, ara, wd, cyc, fail_count, checks_done} = '0;
      {ws, prot} = '0;
      pv = 4'h0;
      wsel = 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h0000ffff);
      axw(`OSPT_OFS_CNT, 32'h00001234);
      chk(rs, `OSPT_RESP_SLVERR);
      axr(8'h30);
      chk(rs, `OSPT_RESP_SLVERR);
      chk(rdv, 32'h0);
      axw(`OSPT_OFS_IOC2, 32'h000000ff);
      axr(`OSPT_OFS_IOC2);
      chk(rdv, 32'h0000000f);
      shot(16'h0003, 16'h0001, 16'h0000, 16'h0004, 1'b0);
      axw(`OSPT_OFS_IOC2, 32'h00000005);
      shot(16'h0014, 16'h0005, 16'h0014, 16'h0015, 1'b1);
      // stop in mid-run by clearing count enable
      axw(`OSPT_OFS_CCR0, 32'h000000c8);
      axw(`OSPT_OFS_CTL1, 32'h00000043);
      repeat (10) @(posedge aclk);
      axw(`OSPT_OFS_CTL0, 32'h00000000);
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h0000ffff);
      chk(p0, 1'b0);
      // external event clock: counter holds until event edges arrive
      axw(`OSPT_OFS_CCR0, 32'h00000002);
      axw(`OSPT_OFS_CTL0, 32'h00000087);
      // software trigger without its byte lane must not fire
      wsel = 4'he;
      axw(`OSPT_OFS_CTL1, 32'h00000043);
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h0000ffff);
      wsel = 4'hf;
      axw(`OSPT_OFS_CTL1, 32'h00000043);
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h00000000);
      src.fire(1'b1);
      // retrigger between count ticks must not restart the count
      axw(`OSPT_OFS_CTL1, 32'h00000043);
      src.fire(1'b1);
      axr(`OSPT_OFS_CNT);
      chk(rdv, 32'h00000002);
      src.fire(1'b1);
      axr(`OSPT_OFS_STAT);
      chk(rdv, 32'h00000002);
      // idle levels: output 0 disabled high, channel 2 active-low
      axw(`OSPT_OFS_CTL0, 32'h00000000);
      axw(`OSPT_OFS_IOC0, 32'h00000032);
      repeat (3) @(posedge aclk);
      chk({p0, pulse_pin}, 4'b1010);
      // byte-lane write touches only the low byte of a compare
      wsel = 4'h1;
      axw(`OSPT_OFS_CCR1, 32'h0000abcd);
      wsel = 4'hf;
      axr(`OSPT_OFS_CCR1);
      chk(rdv, 32'h000000cd);
      finish_test();
   end
endmodule
`default_nettype wire

// ===== bench/ospt_trig_src.sv
// trigger and event source model facing the timer input pins
`timescale 1ns/1ns
`default_nettype none
module ospt_trig_src (
   // clock
   input wire logic aclk,
   // pins toward the timer
   output logic ext_trigger_pin,
   output logic ext_event_pin
);
   // pins rest low between pulses, like a pulled-down line
   initial begin
      ext_trigger_pin = 1'b0;
      ext_event_pin = 1'b0;
   end
   // one clean pulse, held long enough for the two-flop sync
   task automatic fire(input bit ev);
      @(posedge aclk);
      if (ev) ext_event_pin <= 1'b1;
      else ext_trigger_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_event_pin <= 1'b0;
      ext_trigger_pin <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
endmodule
`default_nettype wire

// ===== hw/ospt_chan.sv
// one compare channel: sets its active flag and match pulse on a counter match
`timescale 1ns/1ns
`default_nettype none
module ospt_chan
   import ospt_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link to the counter core
   ospt_chan_if.chan ch
);
   logic active_r;
   logic match_r;
   logic hit;

   // a compare above the period can never be reached before the end
   assign hit = ch.load && (ch.cnt_nxt == ch.cmp) && (ch.cmp <= ch.period);

   // active from the match until the pulse ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         active_r <= 1'b0;
      end else if (ch.clear) begin
         active_r <= 1'b0;
      end else if (hit) begin
         active_r <= 1'b1;
      end
   end

   // match pulse lands with the output change, not one count later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_r <= 1'b0;
      end else begin
         match_r <= hit && !ch.clear;
      end
   end

   assign ch.active = active_r;
   assign ch.match = match_r;
endmodule
`default_nettype wire

// ===== hw/ospt_chan_if.sv
// per-channel link between the counter core and one compare channel
`timescale 1ns/1ns
`default_nettype none
interface ospt_chan_if;
   logic [15:0] cnt_nxt;
   logic load;
   logic clear;
   logic [15:0] period;
   logic [15:0] cmp;
   logic active;
   logic match;
   modport ctl (output cnt_nxt, output load, output clear, output period, output cmp,
                input active, input match);
   modport chan (input cnt_nxt, input load, input clear, input period, input cmp,
                 output active, output match);
endinterface
`default_nettype wire

// ===== hw/ospt_chan_if_unused_placeholder_removed.sv
// intentionally empty compilation unit
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== hw/ospt_params.svh
// register map, field positions and reset values of the one-shot pulse timer
// How it works
// - one-shot pulse mode is selected when the three-bit mode field is 011.
// - setting count enable makes the timer wait for a trigger, not count.
// - a trigger moves the counter from ffff to 0000 and starts pulses.
// - after the pulse the counter reloads ffff, halts and waits again.
// - triggers arriving while a pulse is being output are ignored.
// - output k goes active after channel compare times count clock period.
// - output k stays active for period minus channel compare plus one periods.
// - period match interrupt comes on the count clock after the period match.
// - channel match interrupt comes in the cycle the counter equals its compare.
// - a trigger is the selected external edge or writing 1 to software trigger.
// - output 0 is active while counting and inactive while waiting.
// - each output has enable and level bits; level meaning differs for output 0.
// - edge select register holds trigger and event edge fields, top bits zero.
// - reading counter readback returns the current 16-bit counter value.
// - a channel compare above the period compare gives no pulse on it.
// - compare register writes reach the compare buffer at once.
// - clearing count enable halts counting.
// - lowered compares apply at once; counter wraps through ffff before matching.
`ifndef OSPT_PARAMS_SVH
`define OSPT_PARAMS_SVH
`define OSPT_ADDR_W 8
`define OSPT_OFS_CTL0 8'h00
`define OSPT_OFS_CTL1 8'h04
`define OSPT_OFS_IOC0 8'h08
`define OSPT_OFS_IOC2 8'h0c
`define OSPT_OFS_CNT 8'h10
`define OSPT_OFS_CCR0 8'h14
`define OSPT_OFS_CCR1 8'h18
`define OSPT_OFS_CCR2 8'h1c
`define OSPT_OFS_CCR3 8'h20
`define OSPT_OFS_STAT 8'h24
`define OSPT_CTL0_CE 7
`define OSPT_CTL1_EST 6
`define OSPT_MODE_ONESHOT 3'h3
`define OSPT_CKS_EVENT 3'h7
`define OSPT_CNT_IDLE 16'hffff
`define OSPT_CNT_START 16'h0000
`define OSPT_RST_REG8 8'h00
`define OSPT_RST_CCR 16'h0000
`define OSPT_IOC2_MASK 8'h0f
`define OSPT_RESP_OKAY 2'h0
`define OSPT_RESP_SLVERR 2'h2
`endif

// ===== hw/ospt_pkg.sv
// types shared by the one-shot pulse timer modules
package ospt_pkg;
   typedef enum logic [2:0] {
      OSPT_IDLE = 3'b001,
      OSPT_WAIT = 3'b010,
      OSPT_RUN = 3'b100
   } ospt_state_t;
   typedef enum logic [1:0] {
      OSPT_EDGE_NONE = 2'h0,
      OSPT_EDGE_RISE = 2'h1,
      OSPT_EDGE_FALL = 2'h2,
      OSPT_EDGE_BOTH = 2'h3
   } ospt_edge_t;
endpackage

// ===== hw/ospt_top.sv
// one-shot pulse timer with axi4-lite register access
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "ospt_params.svh"
module ospt_top
   import ospt_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [`OSPT_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [`OSPT_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // timer pins
   input wire logic ext_trigger_pin,
   input wire logic ext_event_pin,
   output logic output_zero_pin,
   output logic [3:1] pulse_output_pin,
   // match interrupts
   output logic period_match_irq,
   output logic [3:1] channel_match_irq
);
   localparam int NCH = 3;

   // register file
   logic [7:0] control_reg0_r;
   logic [7:0] control_reg1_r;
   logic [7:0] output_control_reg_r;
   logic [7:0] edge_select_reg_r;
   logic [15:0] ccr_r [0:NCH];
   // counter core
   ospt_state_t state_r;
   ospt_state_t state_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [7:0] presc_r;
   logic tick;
   logic trig;
   logic sw_trig;
   logic ext_edge;
   logic evt_edge;
   logic mode_ok;
   logic run_end;
   logic cnt_load;
   logic [NCH:1] chan_act;
   logic [NCH:1] chan_match;
   // pin synchronisers
   logic [1:0] trg_sync_r;
   logic trg_prev_r;
   logic [1:0] evt_sync_r;
   logic evt_prev_r;
   // axi state
   logic aw_have_r;
   logic w_have_r;
   logic [`OSPT_ADDR_W-1:0] aw_addr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_go;
   logic wr_hit;
   logic [31:0] rd_val;
   logic rd_hit;
   logic ar_take;

   // byte-lane merge of a write into the current register value
   function automatic logic [31:0] ospt_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // ---------------- axi4-lite write side ----------------
   // address and data are taken independently, one write at a time
   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_have_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         wdata_r <= '0;
         wstrb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_have_r <= 1'b0;
      end
   end

   // address decode for writes; counter and status are read-only
   always_comb begin
      unique case (aw_addr_r)
         `OSPT_OFS_CTL0, `OSPT_OFS_CTL1, `OSPT_OFS_IOC0, `OSPT_OFS_IOC2,
         `OSPT_OFS_CCR0, `OSPT_OFS_CCR1, `OSPT_OFS_CCR2, `OSPT_OFS_CCR3: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // write response, slverr for an unmapped or read-only address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `OSPT_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `OSPT_RESP_OKAY : `OSPT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control and i/o control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_reg0_r <= `OSPT_RST_REG8;
         control_reg1_r <= `OSPT_RST_REG8;
         output_control_reg_r <= `OSPT_RST_REG8;
         edge_select_reg_r <= `OSPT_RST_REG8;
      end else if (wr_go) begin
         if (aw_addr_r == `OSPT_OFS_CTL0) begin
            control_reg0_r <= 8'(ospt_merge({24'h0, control_reg0_r}, wdata_r,
                                 wstrb_r));
         end
         if (aw_addr_r == `OSPT_OFS_CTL1) begin
            // the software trigger bit never stores, it only fires a pulse
            control_reg1_r <= 8'(ospt_merge({24'h0, control_reg1_r}, wdata_r, wstrb_r))
                              & ~(8'h01 << `OSPT_CTL1_EST);
         end
         if (aw_addr_r == `OSPT_OFS_IOC0) begin
            output_control_reg_r <= 8'(ospt_merge({24'h0, output_control_reg_r}, wdata_r,
                                                  wstrb_r));
         end
         if (aw_addr_r == `OSPT_OFS_IOC2) begin
            edge_select_reg_r <= 8'(ospt_merge({24'h0, edge_select_reg_r}, wdata_r, wstrb_r))
                                 & `OSPT_IOC2_MASK;
         end
      end
   end

   // compare registers double as the compare buffers, so writes act at once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i <= NCH; i++) begin
            ccr_r[i] <= `OSPT_RST_CCR;
         end
      end else if (wr_go) begin
         for (int i = 0; i <= NCH; i++) begin
            if (aw_addr_r == `OSPT_OFS_CCR0 + 8'(4 * i)) begin
               ccr_r[i] <= 16'(ospt_merge({16'h0, ccr_r[i]}, wdata_r, wstrb_r));
            end
         end
      end
   end

   assign sw_trig = wr_go && (aw_addr_r == `OSPT_OFS_CTL1) && wstrb_r[0]
                    && wdata_r[`OSPT_CTL1_EST];

   // ---------------- axi4-lite read side ----------------
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   // read mux, unmapped addresses read zero with slverr
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0;
      unique case (s_axi_araddr)
         `OSPT_OFS_CTL0: rd_val = {24'h0, control_reg0_r};
         `OSPT_OFS_CTL1: rd_val = {24'h0, control_reg1_r};
         `OSPT_OFS_IOC0: rd_val = {24'h0, output_control_reg_r};
         `OSPT_OFS_IOC2: rd_val = {24'h0, edge_select_reg_r};
         `OSPT_OFS_CNT: rd_val = {16'h0, cnt_r};
         `OSPT_OFS_CCR0: rd_val = {16'h0, ccr_r[0]};
         `OSPT_OFS_CCR1: rd_val = {16'h0, ccr_r[1]};
         `OSPT_OFS_CCR2: rd_val = {16'h0, ccr_r[2]};
         `OSPT_OFS_CCR3: rd_val = {16'h0, ccr_r[3]};
         `OSPT_OFS_STAT: rd_val = {29'h0, state_r};
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `OSPT_RESP_OKAY;
      end else if (ar_take) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? `OSPT_RESP_OKAY : `OSPT_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ---------------- pins and count clock ----------------
   // two flops per pin; only the second stage and later feed edge logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trg_sync_r <= 2'h0;
         trg_prev_r <= 1'b0;
         evt_sync_r <= 2'h0;
         evt_prev_r <= 1'b0;
      end else begin
         trg_sync_r <= {trg_sync_r[0], ext_trigger_pin};
         trg_prev_r <= trg_sync_r[1];
         evt_sync_r <= {evt_sync_r[0], ext_event_pin};
         evt_prev_r <= evt_sync_r[1];
      end
   end

   // edge selection for trigger and event inputs
   function automatic logic ospt_edge(input logic [1:0] sel, input logic cur,
                                      input logic prev);
      unique case (ospt_edge_t'(sel))
         OSPT_EDGE_NONE: return 1'b0;
         OSPT_EDGE_RISE: return cur && !prev;
         OSPT_EDGE_FALL: return !cur && prev;
         OSPT_EDGE_BOTH: return cur ^ prev;
      endcase
   endfunction

   assign ext_edge = ospt_edge(edge_select_reg_r[1:0], trg_sync_r[1], trg_prev_r);
   assign evt_edge = ospt_edge(edge_select_reg_r[3:2], evt_sync_r[1], evt_prev_r);

   // free-running prescaler; select 7 counts external events instead
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_r <= 8'h00;
      end else begin
         presc_r <= presc_r + 8'h01;
      end
   end

   assign tick = (control_reg0_r[2:0] == `OSPT_CKS_EVENT) ? evt_edge :
                 ((presc_r & ((8'h01 << control_reg0_r[2:0]) - 8'h01)) ==
                  ((8'h01 << control_reg0_r[2:0]) - 8'h01));

   // ---------------- counter core ----------------
   assign mode_ok = (control_reg1_r[2:0] == `OSPT_MODE_ONESHOT);
   assign trig = ext_edge || sw_trig;
   assign run_end = (state_r == OSPT_RUN) && tick && (cnt_r == ccr_r[0]);

   // sequencing: wait for trigger, count once, return to waiting
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cnt_load = 1'b0;
      if (!control_reg0_r[`OSPT_CTL0_CE] || !mode_ok) begin
         state_nxt = OSPT_IDLE;
         cnt_nxt = `OSPT_CNT_IDLE;
      end else begin
         unique case (state_r)
            OSPT_IDLE: begin
               state_nxt = OSPT_WAIT;
            end
            OSPT_WAIT: begin
               if (trig) begin
                  state_nxt = OSPT_RUN;
                  cnt_nxt = `OSPT_CNT_START;
                  cnt_load = 1'b1;
               end
            end
            OSPT_RUN: begin
               // triggers are not looked at here at all
               if (run_end) begin
                  state_nxt = OSPT_WAIT;
                  cnt_nxt = `OSPT_CNT_IDLE;
               end else if (tick) begin
                  cnt_nxt = cnt_r + 16'h0001;
                  cnt_load = 1'b1;
               end
            end
            default: begin
               state_nxt = OSPT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= OSPT_IDLE;
         cnt_r <= `OSPT_CNT_IDLE;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // period match flag rises one count clock after the match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_match_irq <= 1'b0;
      end else begin
         period_match_irq <= run_end && control_reg0_r[`OSPT_CTL0_CE] && mode_ok;
      end
   end

   // ---------------- compare channels ----------------
   generate
      for (genvar k = 1; k <= NCH; k++) begin : g_ch
         ospt_chan_if cif ();
         assign cif.cnt_nxt = cnt_nxt;
         assign cif.load = cnt_load;
         assign cif.clear = (state_nxt != OSPT_RUN);
         assign cif.period = ccr_r[0];
         assign cif.cmp = ccr_r[k];
         assign chan_act[k] = cif.active;
         assign chan_match[k] = cif.match;
         ospt_chan u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .ch(cif)
         );
      end
   endgenerate

   assign channel_match_irq = chan_match;

   // pin drivers, registered; disabled channel outputs rest low, disabled output 0 rests at its level bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_zero_pin <= 1'b0;
         pulse_output_pin <= '0;
      end else begin
         output_zero_pin <= output_control_reg_r[0] ? (state_r == OSPT_RUN)
                                                    : output_control_reg_r[1];
         for (int k = 1; k <= NCH; k++) begin
            pulse_output_pin[k] <= output_control_reg_r[2*k] &&
                                   (chan_act[k] ^ output_control_reg_r[2*k+1]);
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chk_trig_starts: assert property (
      state_r == OSPT_WAIT && trig && control_reg0_r[`OSPT_CTL0_CE] && mode_ok
      |=> state_r == OSPT_RUN && cnt_r == `OSPT_CNT_START)
      else $error("trigger did not start the counter at zero");
   chk_wait_holds: assert property (
      state_r == OSPT_WAIT |-> cnt_r == `OSPT_CNT_IDLE)
      else $error("counter not held at ffff while waiting");
   chk_end_reload: assert property (
      run_end && control_reg0_r[`OSPT_CTL0_CE] && mode_ok
      |=> state_r == OSPT_WAIT && cnt_r == `OSPT_CNT_IDLE && period_match_irq)
      else $error("pulse end did not reload and flag period match");
   chk_trig_ignored: assert property (
      state_r == OSPT_RUN && trig && !run_end && !tick && $stable(control_reg0_r)
      && mode_ok |=> state_r == OSPT_RUN && cnt_r == $past(cnt_r))
      else $error("trigger disturbed a running pulse");
   chk_cnt_advance: assert property (
      state_r == OSPT_RUN && tick && !run_end && control_reg0_r[`OSPT_CTL0_CE] && mode_ok
      |=> cnt_r == $past(cnt_r) + 16'h0001)
      else $error("counter did not advance on count clock");
   chk_match_align: assert property (
      channel_match_irq[1] |-> chan_act[1] && cnt_r == ccr_r[1])
      else $error("channel match not aligned with output change");
   chk_no_long_cmp: assert property (
      $rose(chan_act[1]) |-> $past(ccr_r[1]) <= $past(ccr_r[0]))
      else $error("pulse produced with compare above period");
   chk_out0_run: assert property (
      state_r == OSPT_RUN && output_control_reg_r[0] |=> output_zero_pin)
      else $error("output zero inactive while counting");
   chk_ce_stop: assert property (
      !control_reg0_r[`OSPT_CTL0_CE] |=> state_r == OSPT_IDLE ##1 state_r != OSPT_RUN)
      else $error("counting continued after enable cleared");
   chk_cnt_read: assert property (
      ar_take && s_axi_araddr == `OSPT_OFS_CNT |=> s_axi_rdata == {16'h0, $past(cnt_r)})
      else $error("counter readback mismatch");

   cov_start: cover property (state_r == OSPT_WAIT ##1 state_r == OSPT_RUN);
   cov_period: cover property (period_match_irq);
   cov_chan: cover property (channel_match_irq[1] ##[1:300] period_match_irq);
endmodule
`default_nettype wire
